// ==== src/cmb_store.sv ====
// message buffer store: one receive slot, three transmit slots, ahb-lite access
// ------------------------------------------------------------------
// ------------------------------------------------------------------
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps

module cmb_store
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // protocol engine, transmit side
  input wire logic [cmb_pkg::NUM_TX-1:0] tx_buffer_empty_flag,
  input wire logic tx_sof_req,
  output logic tx_sel_done,
  output logic tx_sel_hit,
  output logic [1:0] tx_sel_index,
  output cmb_pkg::cmb_frame_t tx_frame,
  // protocol engine, receive side
  input wire logic rx_store,
  input wire cmb_pkg::cmb_frame_t rx_frame
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // byte count from length code and frame type
  function automatic logic [3:0] byte_count(input logic [3:0] code, input logic rtr);
    logic [3:0] cnt;
    cnt = (code > cmb_pkg::MAX_COUNT) ? cmb_pkg::MAX_COUNT : code;
    if (rtr)
    begin
      cnt = 4'h0;
    end
    return cnt;
  endfunction : byte_count

  // rebuild a frame from the four identifier bytes and the length byte
  function automatic cmb_pkg::cmb_frame_t unpack(input logic [7:0] b0, input logic [7:0] b1,
                                                 input logic [7:0] b2, input logic [7:0] b3,
                                                 input logic [7:0] len);
    cmb_pkg::cmb_frame_t f;
    f = '0;
    f.ide = b1[cmb_pkg::IDE_BIT];
    if (f.ide)
    begin
      // msb of the identifier sits in bit 28, sent first by the engine
      f.ident = {b0, b1[7:5], b1[2:0], b2, b3[7:1]};
      f.srr = b1[cmb_pkg::SRR_BIT];
      f.rtr = b3[cmb_pkg::RTR_EXT_BIT];
    end
    else
    begin
      f.ident = {18'h00000, b0, b1[7:5]};
      f.rtr = b1[cmb_pkg::RTR_STD_BIT];
    end
    f.length_code_bits = len[3:0];
    f.byte_count = byte_count(len[3:0], f.rtr);
    return f;
  endfunction : unpack

  // pending transmit buffer with lowest priority, ties to lowest index
  function automatic logic [2:0] pick(input logic [cmb_pkg::NUM_TX-1:0] empty,
                                      input logic [cmb_pkg::NUM_TX-1:0][7:0] prio);
    logic hit;
    logic [1:0] idx;
    logic [7:0] best;
    hit = 1'b0;
    idx = 2'h0;
    best = 8'hff;
    for (int i = 0; i < cmb_pkg::NUM_TX; i++)
    begin
      // strict compare keeps the earlier index on a tie
      if (!empty[i] && (!hit || prio[i] < best))
      begin
        hit = 1'b1;
        idx = 2'(i);
        best = prio[i];
      end
    end
    return {hit, idx};
  endfunction : pick

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------

  // slot 0 receive, slots 1..3 transmit; no reset on purpose
  // software must fill a slot completely before marking it pending
  logic [7:0] mem_q [cmb_pkg::NUM_SLOT][cmb_pkg::FRAME_BYTES];
  logic [cmb_pkg::NUM_TX-1:0][7:0] prio_q;

  // ----------------------------------------------------------------
  // ahb address decode
  // ----------------------------------------------------------------
  logic [8:0] a_idx;
  logic a_in_win;
  logic [1:0] a_slot;
  logic [3:0] a_ofs;
  logic a_take;
  logic a_wr;
  logic a_rd;
  logic [7:0] a_rd_byte;

  // index = byte address / 4; window is index 0x140..0x17f
  // only nonseq starts a transfer; idle cycles are ignored
  assign a_idx = haddr[cmb_pkg::ADDR_IDX_LSB +: 9];
  assign a_in_win = (haddr[31:11] == 21'h000000) && (a_idx[8:6] == cmb_pkg::WIN_TAG);
  assign a_slot = a_idx[5:4];
  assign a_ofs = a_idx[3:0];
  assign a_take = hsel && hready && (htrans == cmb_pkg::HTRANS_NONSEQ);
  assign a_wr = a_take && hwrite;
  assign a_rd = a_take && !hwrite;

  // write permitted: transmit slot, frame byte or priority byte
  function automatic logic writable(input logic in_win, input logic [1:0] slot,
                                    input logic [3:0] ofs);
    return in_win && (slot != cmb_pkg::SLOT_RX) && (ofs <= cmb_pkg::OFS_PRIO);
  endfunction : writable

  // read value of one register, zero for unused and unmapped bytes
  function automatic logic [7:0] reg_byte(input logic in_win, input logic [1:0] slot,
                                          input logic [3:0] ofs);
    logic [7:0] v;
    v = 8'h00;
    if (in_win && ofs < cmb_pkg::OFS_PRIO)
    begin
      v = mem_q[slot][ofs];
    end
    else if (in_win && ofs == cmb_pkg::OFS_PRIO && slot != cmb_pkg::SLOT_RX)
    begin
      v = prio_q[slot - 2'h1];
    end
    if (in_win && ofs == cmb_pkg::OFS_LEN)
    begin
      v = {4'h0, v[3:0]};
    end
    return v;
  endfunction : reg_byte

  // ----------------------------------------------------------------
  // ahb data phase
  // ----------------------------------------------------------------
  cmb_pkg::cmb_wr_t wr_q;
  cmb_pkg::cmb_wr_t wr_d;
  logic fwd_hit;
  logic [7:0] wdat;

  assign wr_d.pend = a_wr && writable(a_in_win, a_slot, a_ofs);
  assign wr_d.slot = a_slot;
  assign wr_d.ofs = a_ofs;
  // narrow data sits in lane 0; upper lanes are ignored
  // hsize is not decoded, so a byte written to lanes 1..3 is lost
  assign wdat = hwdata[7:0];
  // a read right behind a write to the same register sees the new value
  // only inside the window, so an alias outside it never forwards
  assign fwd_hit = wr_q.pend && a_in_win && (wr_q.slot == a_slot) && (wr_q.ofs == a_ofs);

  // read value; a process, not an assign, so storage changes are seen
  // even while the address stands still
  always_comb
  begin
    a_rd_byte = reg_byte(a_in_win, a_slot, a_ofs);
    if (fwd_hit)
    begin
      a_rd_byte = (a_ofs == cmb_pkg::OFS_LEN) ? {4'h0, wdat[3:0]} : wdat;
    end
  end

  // pending write and read data register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= '0;
      hrdata <= 32'h00000000;
    end
    else
    begin
      wr_q <= wr_d;
      if (a_rd)
      begin
        hrdata <= {24'h000000, a_rd_byte};
      end
    end
  end

  // zero wait states and always okay
  // a store this small never needs to stall the bus
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= cmb_pkg::HRESP_OKAY;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= cmb_pkg::HRESP_OKAY;
    end
  end

  // ----------------------------------------------------------------
  // receive packing
  // ----------------------------------------------------------------
  logic [7:0] rx_b0;
  logic [7:0] rx_b1;
  logic [7:0] rx_b2;
  logic [7:0] rx_b3;
  logic [3:0] rx_cnt;

  // extended and standard layouts share bytes 0 and 1 head bits
  assign rx_b0 = rx_frame.ide ? rx_frame.ident[28:21] : rx_frame.ident[10:3];
  assign rx_b1 = rx_frame.ide
                 ? {rx_frame.ident[20:18], rx_frame.srr, 1'b1, rx_frame.ident[17:15]}
                 : {rx_frame.ident[2:0], rx_frame.rtr, 1'b0, 3'h0};
  assign rx_b2 = rx_frame.ident[14:7];
  assign rx_b3 = {rx_frame.ident[6:0], rx_frame.rtr};
  assign rx_cnt = byte_count(rx_frame.length_code_bits, rx_frame.rtr);

  // ----------------------------------------------------------------
  // storage writes
  // ----------------------------------------------------------------

  // receive slot from the engine, transmit slots from the bus
  // standard frames leave identifier bytes 2 and 3 as they were
  always_ff @(posedge hclk)
  begin
    if (rx_store)
    begin
      mem_q[cmb_pkg::SLOT_RX][cmb_pkg::OFS_ID0] <= rx_b0;
      mem_q[cmb_pkg::SLOT_RX][cmb_pkg::OFS_ID1] <= rx_b1;
      if (rx_frame.ide)
      begin
        mem_q[cmb_pkg::SLOT_RX][cmb_pkg::OFS_ID2] <= rx_b2;
        mem_q[cmb_pkg::SLOT_RX][cmb_pkg::OFS_ID3] <= rx_b3;
      end
      for (int i = 0; i < cmb_pkg::DATA_BYTES; i++)
      begin
        if (4'(i) < rx_cnt)
        begin
          mem_q[cmb_pkg::SLOT_RX][cmb_pkg::OFS_DATA0 + 4'(i)] <= rx_frame.data[i];
        end
      end
      mem_q[cmb_pkg::SLOT_RX][cmb_pkg::OFS_LEN] <= {4'h0, rx_frame.length_code_bits};
    end
    if (wr_q.pend && wr_q.ofs < cmb_pkg::OFS_PRIO)
    begin
      mem_q[wr_q.slot][wr_q.ofs] <= wdat;
    end
  end

  // local priority bytes of the transmit slots
  // receive slot has no priority byte; writable keeps slot 0 out
  always_ff @(posedge hclk)
  begin
    if (wr_q.pend && wr_q.ofs == cmb_pkg::OFS_PRIO)
    begin
      prio_q[wr_q.slot - 2'h1] <= wdat;
    end
  end

  // ----------------------------------------------------------------
  // transmit selection
  // ----------------------------------------------------------------
  logic [2:0] sel;
  logic [1:0] sel_slot;
  cmb_pkg::cmb_frame_t sel_frame;

  // snapshot taken at the sof request; software must leave pending slots alone
  assign sel = pick(tx_buffer_empty_flag, prio_q);
  assign sel_slot = sel[1:0] + 2'h1;
  always_comb
  begin
    sel_frame = unpack(mem_q[sel_slot][cmb_pkg::OFS_ID0], mem_q[sel_slot][cmb_pkg::OFS_ID1],
                       mem_q[sel_slot][cmb_pkg::OFS_ID2], mem_q[sel_slot][cmb_pkg::OFS_ID3],
                       mem_q[sel_slot][cmb_pkg::OFS_LEN]);
    for (int i = 0; i < cmb_pkg::DATA_BYTES; i++)
    begin
      // bytes beyond the count are zeroed so stale data never leaks out
      sel_frame.data[i] = (4'(i) < sel_frame.byte_count)
                          ? mem_q[sel_slot][cmb_pkg::OFS_DATA0 + 4'(i)] : 8'h00;
    end
  end

  // selection result, one done pulse per request
  // hit, index and frame stand until the next request
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_sel_done <= 1'b0;
      tx_sel_hit <= 1'b0;
      tx_sel_index <= 2'h0;
      tx_frame <= '0;
    end
    else
    begin
      tx_sel_done <= tx_sof_req;
      if (tx_sof_req)
      begin
        tx_sel_hit <= sel[2];
        tx_sel_index <= sel[1:0];
        tx_frame <= sel[2] ? sel_frame : '0;
      end
    end
  end

endmodule : cmb_store

// ==== src/cmb_pkg.sv ====
// shared constants and carriers for the message buffer store
package cmb_pkg;

  // ---------------------------------------------------------------
  // buffer geometry
  // ---------------------------------------------------------------
  localparam int unsigned NUM_SLOT = 4;
  localparam int unsigned NUM_TX = 3;
  localparam int unsigned FRAME_BYTES = 13;
  localparam int unsigned DATA_BYTES = 8;

  // ---------------------------------------------------------------
  // register indices inside a slot (byte address is four times this)
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_ID0 = 4'h0;
  localparam logic [3:0] OFS_ID1 = 4'h1;
  localparam logic [3:0] OFS_ID2 = 4'h2;
  localparam logic [3:0] OFS_ID3 = 4'h3;
  localparam logic [3:0] OFS_DATA0 = 4'h4;
  localparam logic [3:0] OFS_LEN = 4'hc;
  localparam logic [3:0] OFS_PRIO = 4'hd;

  // slot nibble values 4..7 give index 0x140..0x17f, bits [8:6] = 101
  localparam logic [2:0] WIN_TAG = 3'h5;
  localparam logic [1:0] SLOT_RX = 2'h0;
  localparam int unsigned ADDR_IDX_LSB = 2;

  // ---------------------------------------------------------------
  // identifier byte field positions and byte count limit
  // ---------------------------------------------------------------
  localparam int unsigned SRR_BIT = 4;
  localparam int unsigned IDE_BIT = 3;
  localparam int unsigned RTR_STD_BIT = 4;
  localparam int unsigned RTR_EXT_BIT = 0;
  localparam logic [3:0] MAX_COUNT = 4'h8;

  // ---------------------------------------------------------------
  // ahb encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // one frame as the protocol engine sees it
  typedef struct packed {
    logic [28:0] ident;
    logic ide;
    logic srr;
    logic rtr;
    logic [3:0] length_code_bits;
    logic [3:0] byte_count;
    logic [DATA_BYTES-1:0][7:0] data;
  } cmb_frame_t;

  // latched data-phase state of a bus write
  typedef struct packed {
    logic pend;
    logic [1:0] slot;
    logic [3:0] ofs;
  } cmb_wr_t;

endpackage : cmb_pkg

// ==== tb/cmb_store_assertions.sv ====
// output checker for the message buffer store
`timescale 1ns/10ps

module cmb_store_assertions
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus answers
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // transmit selection
  input wire logic [cmb_pkg::NUM_TX-1:0] tx_buffer_empty_flag,
  input wire logic tx_sof_req,
  input wire logic tx_sel_done,
  input wire logic tx_sel_hit,
  input wire logic [1:0] tx_sel_index,
  input wire cmb_pkg::cmb_frame_t tx_frame
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_bus_okay: assert property (hresp == cmb_pkg::HRESP_OKAY && hreadyout)
    else $error("bus answer not okay or not ready");
  a_rd_byte: assert property (hrdata[31:8] == 24'h0)
    else $error("read data above the low byte");
  a_done_follows: assert property (tx_sof_req |=> tx_sel_done)
    else $error("selection not done one cycle after request");
  a_done_pulse: assert property (!tx_sof_req |=> !tx_sel_done)
    else $error("selection done without request");
  a_hit_pending: assert property (tx_sof_req |=> tx_sel_hit == ($past(tx_buffer_empty_flag) != 3'h7))
    else $error("hit does not match the pending set");
  a_win_pending: assert property (tx_sof_req |=> !tx_sel_hit ||
    ((($past(tx_buffer_empty_flag) >> tx_sel_index) & 3'h1) == 3'h0))
    else $error("winner was not pending");
  a_rtr_nodata: assert property (tx_sel_done && tx_frame.rtr |->
    tx_frame.byte_count == 4'h0 && tx_frame.data == '0)
    else $error("remote frame carries data");
  a_count_code: assert property (tx_sel_done && !tx_frame.rtr |-> tx_frame.byte_count ==
    ((tx_frame.length_code_bits > cmb_pkg::MAX_COUNT) ? cmb_pkg::MAX_COUNT : tx_frame.length_code_bits))
    else $error("byte count does not follow length code");
  a_miss_zero: assert property (tx_sel_done && !tx_sel_hit |-> tx_frame == '0)
    else $error("frame not cleared when nothing pending");
  a_std_upper: assert property (tx_sel_done && tx_sel_hit && !tx_frame.ide |->
    tx_frame.ident[28:11] == 18'h0)
    else $error("standard identifier has upper bits");
  a_sel_hold: assert property (!tx_sof_req |=> $stable(tx_sel_index) && $stable(tx_frame))
    else $error("selection result moved without request");
endmodule : cmb_store_assertions

bind cmb_store cmb_store_assertions cmb_store_assertions_i (.hclk, .hresetn, .hrdata,
  .hreadyout, .hresp, .tx_buffer_empty_flag, .tx_sof_req, .tx_sel_done, .tx_sel_hit,
  .tx_sel_index, .tx_frame);

// ==== tb/cmb_engine_model.sv ====
// protocol engine model facing the buffer store
`timescale 1ns/10ps

module cmb_engine_model
(
  // clock
  input wire logic hclk,
  // transmit side
  output logic [cmb_pkg::NUM_TX-1:0] tx_buffer_empty_flag,
  output logic tx_sof_req,
  // receive side
  output logic rx_store,
  output cmb_pkg::cmb_frame_t rx_frame
);
  // idle: all buffers empty, no pulses
  initial
  begin
    tx_buffer_empty_flag = 3'h7;
    tx_sof_req = 1'b0;
    rx_store = 1'b0;
    rx_frame = '0;
  end

  // received frame, then lines scrambled so a stale frame is never reused
  task automatic store(input cmb_pkg::cmb_frame_t f);
    @(posedge hclk);
    rx_frame <= f;
    rx_store <= 1'b1;
    @(posedge hclk);
    rx_store <= 1'b0;
    rx_frame <= ~f;
  endtask : store

  // start of frame with a pending set; afterwards all sent, buffers free
  task automatic sof(input logic [2:0] fl);
    @(posedge hclk);
    tx_buffer_empty_flag <= fl;
    tx_sof_req <= 1'b1;
    @(posedge hclk);
    tx_sof_req <= 1'b0;
    tx_buffer_empty_flag <= 3'h7;
  endtask : sof
endmodule : cmb_engine_model

// ==== tb/cmb_store_tb_top.sv ====
// self-checking bench for the message buffer store
`timescale 1ns/10ps

module cmb_store_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic rd_ph = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, tx_sel_done, tx_sel_hit, tx_sof_req, rx_store;
  logic [1:0] tx_sel_index;
  logic [2:0] tx_buffer_empty_flag, fl;
  cmb_pkg::cmb_frame_t tx_frame, rx_frame, rf, f;
  logic [7:0] mem [4][16];
  logic [7:0] d;
  logic [8:0] best;
  logic [63:0] e;
  logic [63:0] rd_q [$];
  logic [111:0] sel_q [$];
  int errors = 0;
  int compares = 0;
  int w, n;

  always #5 hclk = ~hclk;

  cmb_store cmb_store_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tx_buffer_empty_flag,
    .tx_sof_req, .tx_sel_done, .tx_sel_hit, .tx_sel_index, .tx_frame, .rx_store, .rx_frame);
  cmb_engine_model cmb_engine_model_i (.hclk, .tx_buffer_empty_flag, .tx_sof_req, .rx_store,
    .rx_frame);

  // ---------------------------------------------------------------
  // checking and bus helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [111:0] seen, input logic [111:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    if (errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // bounded wait for ready; a hang ends the run
  task automatic wait_rdy;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      errors++;
      test_done();
    end
  endtask : wait_rdy

  // expected read: mask in the upper half, value in the lower
  function automatic logic [63:0] expv(int s, logic [3:0] o);
    logic [31:0] v;
    v = (s > 3 || o > 4'hd || (s == 0 && o == 4'hd)) ? 32'h0 : {24'h0, mem[s][o]};
    if (o == 4'hc)
      v = v & 32'hf;
    // standard receive layout leaves the low three bits of byte one open
    return {(s == 0 && o == 4'h1 && !mem[0][1][3]) ? 32'hfffffff8 : 32'hffffffff, v};
  endfunction : expv

  task automatic bus(input logic wr, input int s, input logic [3:0] o, input logic [7:0] dv);
    haddr <= 32'h500 + 32'(s) * 32'h40 + 32'(o) * 32'h4;
    htrans <= cmb_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsel <= 1'b1;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, dv};
    rd_ph <= !wr;
    if (!wr)
      rd_q.push_back(expv(s, o));
    wait_rdy();
    rd_ph <= 1'b0;
    if (wr && s > 0 && s < 4 && o < 4'he)
      mem[s][o] = dv;
  endtask : bus

  // expected selection result from the stored slot
  function automatic logic [111:0] txexp(int s);
    cmb_pkg::cmb_frame_t x;
    x = '0;
    x.ide = mem[s][1][3];
    if (x.ide)
      x.ident = {mem[s][0], mem[s][1][7:5], mem[s][1][2:0], mem[s][2], mem[s][3][7:1]};
    else
      x.ident = {18'h0, mem[s][0], mem[s][1][7:5]};
    x.srr = x.ide & mem[s][1][4];
    x.rtr = x.ide ? mem[s][3][0] : mem[s][1][4];
    x.length_code_bits = mem[s][12][3:0];
    x.byte_count = x.rtr ? 4'h0 : (x.length_code_bits > 4'h8 ? 4'h8 : x.length_code_bits);
    for (int i = 0; i < 8; i++)
      if (i < x.byte_count)
        x.data[i] = mem[s][4+i];
    return {5'h0, 1'b1, 2'(s - 1), x};
  endfunction : txexp

  // result watcher: oldest note against each answer
  always @(posedge hclk)
  begin
    if (rd_ph)
    begin
      e = rd_q.pop_front();
      check(112'(hrdata & e[63:32]), 112'(e[31:0] & e[63:32]));
    end
    if (tx_sel_done === 1'b1)
    begin
      f = tx_frame;
      f.srr = f.srr & f.ide;
      check({5'h0, tx_sel_hit, tx_sel_hit ? tx_sel_index : 2'h0, f}, sel_q.pop_front());
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h6f052b5a));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    // receive frames, bus write to the read-only slot, full read back
    for (int k = 0; k < 6; k++)
    begin
      rf = 104'({$urandom, $urandom, $urandom, $urandom});
      if (k == 0)
        {rf.ide, rf.rtr, rf.length_code_bits} = 6'h28;
      cmb_engine_model_i.store(rf);
      mem[0][12] = {4'h0, rf.length_code_bits};
      if (rf.ide)
        {mem[0][0], mem[0][1], mem[0][2], mem[0][3]} = {rf.ident[28:18], rf.srr, 1'b1,
          rf.ident[17:0], rf.rtr};
      else
        {mem[0][0], mem[0][1]} = {rf.ident[10:0], rf.rtr, 4'h0};
      for (int i = 0; i < 8; i++)
        if (!rf.rtr && (i < rf.length_code_bits || rf.length_code_bits > 4'h8))
          mem[0][4+i] = rf.data[i];
      bus(1'b1, 0, 4'h4, 8'(~rf.data[0]));
      // receive slot is always read only, so the write above must leave it as stored
      for (int o = 0; o < 16; o++)
        bus(1'b0, 0, 4'(o), 8'h0);
    end
    // random slots and priorities (ties and 0xff), then a selection
    for (int k = 0; k < 16; k++)
    begin
      for (int s = 1; s < 4; s++)
        for (int o = 0; o < 16; o++)
        begin
          d = 8'($urandom);
          if (o == 1 && d[3])
            d[4] = 1'b1;
          if (o == 13)
            d = (d[1:0] == 2'h3) ? 8'hff : {6'h0, d[1:0]};
          bus(1'b1, s, 4'(o), d);
          bus(1'b0, s, 4'(o), 8'h0);
        end
      fl = (k == 0) ? 3'h7 : 3'($urandom);
      best = 9'h100;
      w = 0;
      for (int i = 0; i < 3; i++)
        if (!fl[i] && {1'b0, mem[i+1][13]} < best)
        begin
          best = {1'b0, mem[i+1][13]};
          w = i + 1;
        end
      sel_q.push_back(w > 0 ? txexp(w) : 112'h0);
      cmb_engine_model_i.sof(fl);
    end
    bus(1'b0, 4, 4'h0, 8'h0);
    repeat (3) @(posedge hclk);
    test_done();
  end
endmodule : cmb_store_tb_top
